// [logic/sbst_regs.vh]
/*
  constants of the sram boundary-scan test port: instruction codes, scan lengths,
  register offsets and field positions of the wishbone view.
  assumes it is included by its bare name from the design file.
*/
`ifndef SBST_REGS_VH
`define SBST_REGS_VH

// How it works
// - all test inputs, serial data included, are sampled on test clock rise
// - serial data output changes only on the test clock fall
// - mode select, evaluated at each test clock rise, picks the next tap state
// - an unconnected mode select or data input reads as logic one
// - the held instruction alone picks the register in the serial path
// - serial data enters at the msb and leaves from the lsb
// - serial output is enabled only in the shift states, else high impedance
// - mode select high on five test clock rises always reaches test-logic-reset
// - a tap reset never touches normal memory operation
// - power-up resets the test logic itself, output off, memory untouched
// - exactly one scan register sits between serial input and output
// - the instruction register is three bits, loaded serially in its path
// - instruction register holds the id instruction after power-up and reset
// - capture-ir loads pattern 01 into the two low instruction bits
// - a one-bit bypass register exists and is cleared under bypass
// - the boundary scan register is 71 bits, one per input or two-way ball
// - capture-dr copies the io ring into the boundary register, shift-dr shifts it
// - extest, sample-preload and sample-z select and capture the boundary register
// - the port behaves correctly in a chain shared with compliant ports
// - under the id instruction capture-dr loads a fixed 32-bit code
// - a shifted instruction takes effect only on the test clock rise that leaves update-ir
// - all-zero instruction is extest: like sample-preload plus memory outputs off
// - sample-z selects the boundary register and forces memory outputs off

`define SBST_IR_W        3
`define SBST_BSR_W       71
`define SBST_ID_W        32
`define SBST_ST_W        16

`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDCODE   3'h1
`define SBST_IR_SAMPLEZ  3'h2
`define SBST_IR_SAMPLE   3'h4
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAPT     3'h1

`define SBST_ADDR_W      4
`define SBST_OFS_STATUS  4'h0
`define SBST_OFS_CTRL    4'h4

`define SBST_CTRL_RST    0
`define SBST_STAT_IR_LO  0
`define SBST_STAT_HIZ    3
`define SBST_STAT_ST_LO  16

`endif

// [logic/sbst_tap.v]
/*
  boundary-scan test access port of a burst sram, seen from the core clock.
  assumes the test clock is far slower than i_core_clk (at least four core cycles per
  half period) and that the io ring input is on the core clock.
*/
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "sbst_regs.vh"

module sbst_tap #(
  parameter [31:0] ID_CODE = 32'h1000_0001  // arbitrary value
) (
  input  wire          i_core_clk,
  input  wire          i_rstn,
  input  wire          i_tck,
  input  wire          i_tms,
  input  wire          i_tms_conn,
  input  wire          i_tdi,
  input  wire          i_tdi_conn,
  input  wire [70:0]   i_ring,
  output reg           o_tdo,
  output reg           o_tdo_oe,
  output reg           o_mem_hiz,
  input  wire          i_wb_cyc,
  input  wire          i_wb_stb,
  input  wire          i_wb_we,
  input  wire [3:0]    i_wb_adr,
  input  wire [3:0]    i_wb_sel,
  input  wire [31:0]   i_wb_dat,
  output reg  [31:0]   o_wb_dat,
  output reg           o_wb_ack
);

////////////////////////////////////////////////////////////////////////////////
// tap states, one-hot

localparam [15:0] S_TLR  = 16'h0001;
localparam [15:0] S_RTI  = 16'h0002;
localparam [15:0] S_SDR  = 16'h0004;
localparam [15:0] S_CDR  = 16'h0008;
localparam [15:0] S_SHDR = 16'h0010;
localparam [15:0] S_E1DR = 16'h0020;
localparam [15:0] S_PDR  = 16'h0040;
localparam [15:0] S_E2DR = 16'h0080;
localparam [15:0] S_UDR  = 16'h0100;
localparam [15:0] S_SIR  = 16'h0200;
localparam [15:0] S_CIR  = 16'h0400;
localparam [15:0] S_SHIR = 16'h0800;
localparam [15:0] S_E1IR = 16'h1000;
localparam [15:0] S_PIR  = 16'h2000;
localparam [15:0] S_E2IR = 16'h4000;
localparam [15:0] S_UIR  = 16'h8000;

// next state from the present state and mode select
function [15:0] nxt;
  input [15:0] st;
  input        tms;
  begin
    case (st)
      S_TLR:   nxt = tms ? S_TLR  : S_RTI;
      S_RTI:   nxt = tms ? S_SDR  : S_RTI;
      S_SDR:   nxt = tms ? S_SIR  : S_CDR;
      S_CDR:   nxt = tms ? S_E1DR : S_SHDR;
      S_SHDR:  nxt = tms ? S_E1DR : S_SHDR;
      S_E1DR:  nxt = tms ? S_UDR  : S_PDR;
      S_PDR:   nxt = tms ? S_E2DR : S_PDR;
      S_E2DR:  nxt = tms ? S_UDR  : S_SHDR;
      S_UDR:   nxt = tms ? S_SDR  : S_RTI;
      S_SIR:   nxt = tms ? S_TLR  : S_CIR;
      S_CIR:   nxt = tms ? S_E1IR : S_SHIR;
      S_SHIR:  nxt = tms ? S_E1IR : S_SHIR;
      S_E1IR:  nxt = tms ? S_UIR  : S_PIR;
      S_PIR:   nxt = tms ? S_E2IR : S_PIR;
      S_E2IR:  nxt = tms ? S_UIR  : S_SHIR;
      S_UIR:   nxt = tms ? S_SDR  : S_RTI;
      default: nxt = S_TLR;
    endcase
  end
endfunction

// instruction decode: which data register is in the path
function sel_bsr;
  input [2:0] ir;
  begin
    sel_bsr = (ir == `SBST_IR_EXTEST) || (ir == `SBST_IR_SAMPLE) || (ir == `SBST_IR_SAMPLEZ);
  end
endfunction

function sel_id;
  input [2:0] ir;
  begin
    sel_id = (ir == `SBST_IR_IDCODE);
  end
endfunction

// a floating pin reads as one, as the pull-up would make it
function pulled;
  input conn;
  input pin;
  begin
    pulled = conn ? pin : 1'b1;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

reg        tck_s1_q;
reg        tck_s2_q;
reg        tck_s3_q;
reg        tms_s1_q;
reg        tms_s2_q;
reg        tdi_s1_q;
reg        tdi_s2_q;
reg        tmsc_s1_q;
reg        tmsc_s2_q;
reg        tdic_s1_q;
reg        tdic_s2_q;
wire       tck_rise;
wire       tck_fall;
wire       tms_in;
wire       tdi_in;

always @(posedge i_core_clk or negedge i_rstn)
begin
  if (!i_rstn)
  begin
    tck_s1_q <= 1'b0;
    tck_s2_q <= 1'b0;
    tck_s3_q <= 1'b0;
    tms_s1_q <= 1'b1;
    tms_s2_q <= 1'b1;
    tdi_s1_q <= 1'b1;
    tdi_s2_q <= 1'b1;
    tmsc_s1_q <= 1'b0;
    tmsc_s2_q <= 1'b0;
    tdic_s1_q <= 1'b0;
    tdic_s2_q <= 1'b0;
  end
  else
  begin
    tck_s1_q <= i_tck;
    tck_s2_q <= tck_s1_q;
    tck_s3_q <= tck_s2_q;
    tms_s1_q <= i_tms;
    tms_s2_q <= tms_s1_q;
    tdi_s1_q <= i_tdi;
    tdi_s2_q <= tdi_s1_q;
    tmsc_s1_q <= i_tms_conn;
    tmsc_s2_q <= tmsc_s1_q;
    tdic_s1_q <= i_tdi_conn;
    tdic_s2_q <= tdic_s1_q;
  end
end

// a test clock held low yields no edge, so only the soft test reset moves the tap logic below
assign tck_rise = tck_s2_q & ~tck_s3_q;
assign tck_fall = ~tck_s2_q & tck_s3_q;

// pins as seen after the synchronisers, a floating one reads high
assign tms_in = pulled(tmsc_s2_q, tms_s2_q);
assign tdi_in = pulled(tdic_s2_q, tdi_s2_q);

////////////////////////////////////////////////////////////////////////////////
// tap state machine

reg  [15:0] st_q;
reg  [15:0] st_d;
reg         soft_rst_q;

always @*
begin
  st_d = st_q;
  if (soft_rst_q)
    st_d = S_TLR;
  else if (tck_rise)
    st_d = nxt(st_q, tms_in);
end

// power-up lands in test-logic-reset; no memory path is touched here
always @(posedge i_core_clk or negedge i_rstn)
begin
  if (!i_rstn)
    st_q <= S_TLR;
  else
    st_q <= st_d;
end

////////////////////////////////////////////////////////////////////////////////
// instruction register

reg  [2:0]  ir_sh_q;
reg  [2:0]  ir_q;

always @(posedge i_core_clk or negedge i_rstn)
begin
  if (!i_rstn)
  begin
    ir_sh_q <= `SBST_IR_IDCODE;
    ir_q    <= `SBST_IR_IDCODE;
  end
  else if (st_q == S_TLR)
  begin
    ir_q    <= `SBST_IR_IDCODE;
  end
  else if (tck_rise)
  begin
    case (st_q)
      S_CIR:   ir_sh_q <= `SBST_IR_CAPT;
      S_SHIR:  ir_sh_q <= {tdi_in, ir_sh_q[2:1]};
      S_UIR:   ir_q    <= ir_sh_q;
      default: ir_sh_q <= ir_sh_q;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// data registers

reg  [70:0] bsr_q;
reg  [31:0] idr_q;
reg         byp_q;
wire        use_bsr = sel_bsr(ir_q);
wire        use_id  = sel_id(ir_q);
wire        use_byp = ~use_bsr & ~use_id;

// only the selected register captures or shifts; update-dr is ignored
always @(posedge i_core_clk or negedge i_rstn)
begin
  if (!i_rstn)
  begin
    bsr_q <= {`SBST_BSR_W{1'b0}};
    idr_q <= {`SBST_ID_W{1'b0}};
    byp_q <= 1'b0;
  end
  else if (tck_rise)
  begin
    if (st_q == S_CDR)
    begin
      if (use_bsr)
        bsr_q <= i_ring;
      if (use_id)
        idr_q <= ID_CODE;
      if (use_byp)
        byp_q <= 1'b0;
    end
    else if (st_q == S_SHDR)
    begin
      if (use_bsr)
        bsr_q <= {tdi_in, bsr_q[70:1]};
      if (use_id)
        idr_q <= {tdi_in, idr_q[31:1]};
      if (use_byp)
        byp_q <= tdi_in;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// serial output and memory output control

reg         tdo_d;
reg         tdo_oe_d;

always @*
begin
  tdo_d    = o_tdo;
  tdo_oe_d = o_tdo_oe;
  if (soft_rst_q || st_q == S_TLR)
  begin
    tdo_oe_d = 1'b0;
  end
  else if (tck_fall)
  begin
    tdo_oe_d = (st_q == S_SHIR) || (st_q == S_SHDR);
    if (st_q == S_SHIR)
      tdo_d = ir_sh_q[0];
    else if (use_bsr)
      tdo_d = bsr_q[0];
    else if (use_id)
      tdo_d = idr_q[0];
    else
      tdo_d = byp_q;
  end
end

// tdo changes on the falling test clock only, memory off follows the held instruction; update-dr has no pin effect
always @(posedge i_core_clk or negedge i_rstn)
begin
  if (!i_rstn)
  begin
    o_tdo     <= 1'b1;
    o_tdo_oe  <= 1'b0;
    o_mem_hiz <= 1'b0;
  end
  else
  begin
    o_tdo     <= tdo_d;
    o_tdo_oe  <= tdo_oe_d;
    o_mem_hiz <= (ir_q == `SBST_IR_EXTEST) || (ir_q == `SBST_IR_SAMPLEZ);
  end
end

////////////////////////////////////////////////////////////////////////////////
// wishbone slave: status and soft test reset

wire        wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
wire        wb_ctrl = (i_wb_adr == `SBST_OFS_CTRL);
wire        wb_stat = (i_wb_adr == `SBST_OFS_STATUS);
// soft test reset strobe, self-clearing
wire        wb_soft = wb_req & i_wb_we & wb_ctrl & i_wb_sel[0] & i_wb_dat[`SBST_CTRL_RST];
reg  [31:0] rd_d;

always @*
begin
  rd_d = 32'h0000_0000;
  if (wb_stat)
  begin
    rd_d[`SBST_STAT_IR_LO +: 3] = ir_q;
    rd_d[`SBST_STAT_HIZ]        = o_mem_hiz;
    rd_d[`SBST_STAT_ST_LO +: 16] = st_q;
  end
end

always @(posedge i_core_clk or negedge i_rstn)
begin
  if (!i_rstn)
  begin
    o_wb_ack   <= 1'b0;
    o_wb_dat   <= 32'h0000_0000;
    soft_rst_q <= 1'b0;
  end
  else
  begin
    o_wb_ack   <= wb_req;
    soft_rst_q <= wb_soft;
    if (wb_req && !i_wb_we)
      o_wb_dat <= rd_d;
  end
end

endmodule

// [tb/sbst_jtag_host.sv]
/*
  test controller model: makes tck (320 ns), drives tms and tdi, reads tdo.
  assumes i_core_clk at 40 ns; all changes follow a core clock rise.
*/
`timescale 1ns/1ns
module sbst_jtag_host (
  input  wire i_core_clk,
  input  wire i_tdo,
  output reg  o_tck,
  output reg  o_tms,
  output reg  o_tdi
);
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // one tck period, tms and tdi set up in the low phase
  task step(input logic m, input logic d, output logic q);
    begin
      o_tms <= m;
      o_tdi <= d;
      repeat (4) @(posedge i_core_clk);
      o_tck <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      q = i_tdo;
      @(posedge i_core_clk);
      o_tck <= 1'b0;
    end
  endtask
  // from idle: capture, shift n bits lsb first, update, idle
  task scan(input logic ir, input int n, input logic [71:0] din, output logic [71:0] dout);
    logic q;
    int   i;
    begin
      dout = '0;
      step(1'b1, 1'b0, q);
      if (ir)
        step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (i = 0; i < n; i++)
        step(i == n - 1, din[i], dout[i]);
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
    end
  endtask
  // five tms-high rises, then back to idle
  task tap_reset;
    logic q;
    begin
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
    end
  endtask
endmodule

// [tb/sbst_tap_asserts.sv]
/*
  checker of the test port, bound to sbst_tap.
  assumes one core clock domain and the bench tck rate.
*/
`timescale 1ns/1ns
module sbst_tap_asserts (
  input wire        i_core_clk,
  input wire        i_rstn,
  input wire        i_tck,
  input wire        i_tms,
  input wire        i_tms_conn,
  input wire        o_tdo,
  input wire        o_tdo_oe,
  input wire        o_mem_hiz,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [3:0]  i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  reg       tck_q;
  reg [3:0] fall_n;
  reg [2:0] hi_n;
  always @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tck_q  <= 1'b0;
      fall_n <= 4'hf;
      hi_n   <= 3'h0;
    end
    else
    begin
      tck_q <= i_tck;
      if (tck_q && !i_tck)
        fall_n <= 4'h0;
      else if (fall_n != 4'hf)
        fall_n <= fall_n + 4'h1;
      if (i_tck && !tck_q)
        hi_n <= !(i_tms || !i_tms_conn) ? 3'h0 : (hi_n == 3'h7) ? hi_n : hi_n + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_tdo_on_fall: assert property ($changed(o_tdo) |-> fall_n <= 4'h4)
    else $error("tdo moved away from a tck fall");
  a_oe_on_fall: assert property ($rose(o_tdo_oe) |-> fall_n <= 4'h4)
    else $error("tdo enable rose away from a tck fall");
  a_tms_five: assert property (hi_n == 3'h5 |-> ##[0:5] !o_tdo_oe)
    else $error("five tms rises did not quiet tdo");
  a_ack_once: assert property (s_take |=> s_pulse)
    else $error("ack not a single cycle after take");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_stat_hiz: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr == 4'h0) |->
    o_wb_dat[3] == (o_wb_dat[2:0] == 3'h0 || o_wb_dat[2:0] == 3'h2) && o_wb_dat[3] == o_mem_hiz)
    else $error("memory off flag does not match instruction");
  a_unmapped_zero: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr != 4'h0 && i_wb_adr != 4'h4)
    |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_dat_hold: assert property ($changed(o_wb_dat) |-> o_wb_ack)
    else $error("read data moved without ack");
  a_rst_quiet: assert property ($rose(i_rstn) |-> !o_tdo_oe && !o_mem_hiz && !o_wb_ack)
    else $error("outputs active after reset");
endmodule
bind sbst_tap sbst_tap_asserts chk_u (.*);

// [tb/sbst_tap_tb.sv]
/*
  testbench of sbst_tap: wishbone tasks plus the jtag host model.
  assumes 25 MHz core clock and a 320 ns test clock.
*/
`timescale 1ns/1ns
module sbst_tap_tb;
  logic        clk, rstn, tms_c, tdi_c, cyc, stb, we, ack, tck, tms, tdi, tdo, oe, hiz;
  logic [3:0]  adr;
  logic [31:0] wdat, rd, rdat;
  logic [70:0] ring;
  logic [71:0] so, x, exp_dr;
  int          errors, n_tests, c;
  sbst_tap dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_tck(tck), .i_tms(tms_c ? tms : ~tms),
    .i_tms_conn(tms_c), .i_tdi(tdi_c ? tdi : ~tdi), .i_tdi_conn(tdi_c), .i_ring(ring), .o_tdo(tdo),
    .o_tdo_oe(oe), .o_mem_hiz(hiz), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rd), .o_wb_ack(ack));
  sbst_jtag_host host_u (.i_core_clk(clk), .i_tdo(oe ? tdo : ~tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    begin
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1)
        @(posedge clk);
      rdat = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task chk(input string s, input logic [71:0] got, input logic [71:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        errors++;
        $display("MISMATCH %s exp %h got %h", s, exp, got);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    #3000000;
    errors++;
    results();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, cyc, stb, we, adr, wdat} = '0;
    {tms_c, tdi_c} = 2'b11;
    ring = 71'h1a123456789abcdef0;
    x = 72'hc30f0f3c3ca5a59669;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, 4'h0, 32'h0);
    chk("status", rdat[3:0], 4'h1);
    chk("oe", oe, 1'b0);
    $display("reset test done");
    host_u.tap_reset();
    for (c = 0; c < 8; c++)
    begin
      host_u.scan(1'b1, 3, 72'(c), so);
      chk("ir capture", so[2:0], 3'h1);
      wb(1'b0, 4'h0, 32'h0);
      chk("ir", rdat[3:0], {c == 0 || c == 2, 3'(c)});
      chk("hiz", hiz, c == 0 || c == 2);
      host_u.scan(1'b0, 72, x, so);
      exp_dr = (c == 0 || c == 2 || c == 4) ? {x[0], ring} : (c == 1) ? {x[39:0], 32'h10000001} : {x[70:0], 1'b0};
      chk("dr", so, exp_dr);
      chk("hiz kept", hiz, c == 0 || c == 2);
      chk("oe idle", oe, 1'b0);
    end
    $display("instruction test done");
    tdi_c <= 1'b0;
    host_u.scan(1'b0, 4, 72'h0, so);
    chk("tdi float", so[3:0], 4'he);
    tdi_c <= 1'b1;
    tms_c <= 1'b0;
    host_u.tap_reset();
    tms_c <= 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk("tap reset", rdat[3:0], 4'h1);
    chk("tap state", rdat[31:16], 16'h0001);
    host_u.tap_reset();
    $display("float test done");
    host_u.scan(1'b1, 3, 72'h7, so);
    wb(1'b0, 4'h0, 32'h0);
    chk("ir bypass", rdat[3:0], 4'h7);
    wb(1'b1, 4'h4, 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    chk("soft reset", rdat[3:0], 4'h1);
    chk("soft state", rdat[31:16], 16'h0001);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped", rdat, 32'h0);
    $display("bus test done");
    results();
  end
endmodule
